//--- delta_pkg.sv
// shared constants for the modulator bitstream link and its receiver
package delta_pkg;
  localparam int CLK_MHZ            = 50;
  localparam int IN_W               = 16;
  localparam int ACC_W              = 22;
  // input codes: 1 V equals CODES_PER_VOLT codes, clipping at 1.25 V
  localparam int CODES_PER_VOLT     = 8000;
  localparam int CLIP_MV            = 1250;
  localparam int CLIP_CODE          = CLIP_MV * CODES_PER_VOLT / 1000;
  localparam int CM_LOW_CODE        = -2400;
  localparam int CM_HIGH_CODE       = 24000;
  localparam int CHOP_DIV           = 32;
  localparam int MARK_PERIOD        = 128;
  localparam int MARK_W             = $clog2(MARK_PERIOD);
  localparam int FAULT_RUN          = 128;
  localparam int SCLK_HALF          = 2;
  localparam int CAPTURE_LAG        = 9;
  localparam int DECIM              = 256;
  localparam int WORD_W             = $clog2(DECIM) + 1;
  localparam int FIFO_DEPTH         = 32;
  localparam int ANALOG_SETTLE_US   = 250;
  localparam int SETTLE_CYCLES      = ANALOG_SETTLE_US * CLK_MHZ;
  localparam logic MODE_UNCODED     = 1'b0;
  localparam logic MODE_MANCHESTER  = 1'b1;

  // a synchronised pin counts as changed once stages two and three agree
  function automatic logic agree_change(input logic ff2, input logic ff3, input logic stable);
    agree_change = (ff2 == ff3) && (ff3 != stable);
  endfunction
endpackage

//--- delta_link.sv
// pins between the modulator and the decimating receiver
interface delta_link;
  logic sample_clock;
  logic line_code_select;
  logic bitstream;
  modport device (input sample_clock, input line_code_select, output bitstream);
  modport host   (output sample_clock, output line_code_select, input bitstream);
endinterface

//--- stream_fifo.sv
// synchronous fifo with valid and ready on both sides
module stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

//--- modulator_bitstream_output.sv
// modulator end: second-order one-bit stream, line coding, markers and fail-safe

// How it works
// - one bit per sample clock cycle
// - chopper runs at sample clock over 32
// - other side keeps sample clock running; the receiver here stops it while run is low
// - stopped clock freezes conversion and output
// - receiver distrusts output after clock resumes
// - settle wait is typically 0.25 ms
// - ones density 50, 90, 10 percent
// - density is (vin+clip) over twice clip
// - clip to zeros or ones beyond 1.25 V
// - opposite marker bit every 128 clipped bits
// - markers also sent in Manchester mode
// - uncoded output updates on rising edge
// - receiver captures on rising edge
// - Manchester output is data xor clock
// - select high means Manchester, low uncoded
// - select change while clock high inverts output
// - half bits follow clock high and low
// - common-mode fault holds output high
module modulator_bitstream_output
  import delta_pkg::*;
#(
  parameter int IN_WIDTH   = IN_W,
  parameter int CLIP_LEVEL = CLIP_CODE,
  parameter int CM_LOW     = CM_LOW_CODE,
  parameter int CM_HIGH    = CM_HIGH_CODE,
  parameter int CHOP_RATIO = CHOP_DIV,
  parameter int MARK_EVERY = MARK_PERIOD
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  delta_link.device                       link,
  input  wire logic signed [IN_WIDTH-1:0] analog_in_pos,
  input  wire logic signed [IN_WIDTH-1:0] analog_in_neg,
  output logic                            chop_phase,
  output logic                            clipped,
  output logic                            cm_fault
);
  localparam int DW      = IN_WIDTH + 1;
  localparam int CHOP_W  = $clog2(CHOP_RATIO / 2) + 1;
  localparam int MK_W    = $clog2(MARK_EVERY);
  localparam logic signed [ACC_W-1:0] CLIP_A = ACC_W'(CLIP_LEVEL);
  localparam logic signed [ACC_W-1:0] CM_LO_A = ACC_W'(CM_LOW);
  localparam logic signed [ACC_W-1:0] CM_HI_A = ACC_W'(CM_HIGH);
  localparam logic [CHOP_W-1:0] CHOP_LAST = CHOP_W'(CHOP_RATIO / 2 - 1);
  localparam logic [MK_W-1:0]   MARK_LAST = MK_W'(MARK_EVERY - 1);

  // pin synchronisers
  logic sclk_ff1_r;
  logic sclk_ff2_r;
  logic sclk_ff3_r;
  logic sclk_stable_r;
  logic mode_ff1_r;
  logic mode_ff2_r;
  logic mode_ff3_r;
  logic mode_stable_r;

  logic sclk_change;
  logic sclk_rise;
  logic sclk_fall;
  logic mode_change;
  logic sclk_level_nxt;
  logic mode_nxt;

  // modulator state
  logic signed [ACC_W-1:0] err1_r;
  logic signed [ACC_W-1:0] err2_r;
  logic signed [ACC_W-1:0] vin;
  logic signed [ACC_W-1:0] cm_level;
  logic signed [ACC_W-1:0] loop_sum;
  logic signed [ACC_W-1:0] loop_fb;
  logic                    loop_bit;
  logic                    clip_pos;
  logic                    clip_neg;
  logic                    cm_bad;
  logic [MK_W-1:0]         mark_cnt_r;
  logic                    mark_now;
  logic                    data_r;
  logic                    data_nxt;
  logic                    data_now;
  logic                    fault_r;
  logic                    fault_now;
  logic                    out_r;
  logic [CHOP_W-1:0]       chop_cnt_r;
  logic                    chop_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_ff1_r    <= 1'b0;
      sclk_ff2_r    <= 1'b0;
      sclk_ff3_r    <= 1'b0;
      sclk_stable_r <= 1'b0;
    end else begin
      sclk_ff1_r <= link.sample_clock;
      sclk_ff2_r <= sclk_ff1_r;
      sclk_ff3_r <= sclk_ff2_r;
      if (sclk_change) begin
        sclk_stable_r <= sclk_ff3_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff1_r    <= 1'b0;
      mode_ff2_r    <= 1'b0;
      mode_ff3_r    <= 1'b0;
      mode_stable_r <= MODE_UNCODED;
    end else begin
      mode_ff1_r <= link.line_code_select;
      mode_ff2_r <= mode_ff1_r;
      mode_ff3_r <= mode_ff2_r;
      if (mode_change) begin
        mode_stable_r <= mode_ff3_r;
      end
    end
  end

  assign sclk_change    = agree_change(sclk_ff2_r, sclk_ff3_r, sclk_stable_r);
  assign sclk_rise      = sclk_change && sclk_ff3_r;
  assign sclk_fall      = sclk_change && !sclk_ff3_r;
  assign mode_change    = agree_change(mode_ff2_r, mode_ff3_r, mode_stable_r);
  assign sclk_level_nxt = sclk_change ? sclk_ff3_r : sclk_stable_r;
  assign mode_nxt       = mode_change ? mode_ff3_r : mode_stable_r;

  // chopper phase toggles every half of the division ratio
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chop_cnt_r <= '0;
      chop_r     <= 1'b0;
    end else if (sclk_rise) begin
      if (chop_cnt_r == CHOP_LAST) begin
        chop_cnt_r <= '0;
        chop_r     <= !chop_r;
      end else begin
        chop_cnt_r <= chop_cnt_r + 1'b1;
      end
    end
  end

  // differential and common-mode view of the input
  assign vin      = ACC_W'(DW'(analog_in_pos) - DW'(analog_in_neg));
  assign cm_level = ACC_W'(DW'(analog_in_pos) + DW'(analog_in_neg)) >>> 1;
  assign cm_bad   = (cm_level <= CM_LO_A) || (cm_level >= CM_HI_A);
  assign clip_pos = vin >= CLIP_A;
  assign clip_neg = vin <= -CLIP_A;

  // error-feedback loop with noise shaping (1 - z^-1)^2; the mean of the
  // fed-back level tracks vin, so ones density is (vin + clip) / (2 clip)
  assign loop_sum = vin + (err1_r <<< 1) - err2_r;
  assign loop_bit = !loop_sum[ACC_W-1];
  assign loop_fb  = loop_bit ? CLIP_A : -CLIP_A;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err1_r <= '0;
      err2_r <= '0;
    end else if (sclk_rise) begin
      if (clip_pos || clip_neg) begin
        // loop state is dumped while clipped so it recovers cleanly
        err1_r <= '0;
        err2_r <= '0;
      end else begin
        err1_r <= loop_sum - loop_fb;
        err2_r <= err1_r;
      end
    end
  end

  // marker counter runs only while clipped
  assign mark_now = (clip_pos || clip_neg) && (mark_cnt_r == MARK_LAST);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mark_cnt_r <= '0;
    end else if (sclk_rise) begin
      if (!(clip_pos || clip_neg)) begin
        mark_cnt_r <= '0;
      end else begin
        mark_cnt_r <= mark_cnt_r + 1'b1;
      end
    end
  end

  always_comb begin
    if (clip_pos) begin
      data_nxt = !mark_now;
    end else if (clip_neg) begin
      data_nxt = mark_now;
    end else begin
      data_nxt = loop_bit;
    end
  end

  // one new bit per rising edge; no edge means nothing moves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_r  <= 1'b0;
      fault_r <= 1'b0;
      clipped <= 1'b0;
    end else if (sclk_rise) begin
      data_r  <= data_nxt;
      fault_r <= cm_bad;
      clipped <= clip_pos || clip_neg;
    end
  end

  assign data_now  = sclk_rise ? data_nxt : data_r;
  assign fault_now = sclk_rise ? cm_bad : fault_r;

  // line coder: recomputed on both clock edges and on a mode change, so a
  // select change while the clock is high shows as an inverted half bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_r <= 1'b0;
    end else if (sclk_change || mode_change) begin
      if (fault_now) begin
        out_r <= 1'b1;
      end else if (mode_nxt == MODE_MANCHESTER) begin
        out_r <= data_now ^ sclk_level_nxt;
      end else if (sclk_rise || mode_change) begin
        out_r <= data_now;
      end
    end
  end

  assign link.bitstream = out_r;
  assign chop_phase     = chop_r;
  assign cm_fault       = fault_r;
endmodule

//--- decimating_receiver.sv
// receiver end: makes the sample clock, decodes the stream, counts ones per window
module decimating_receiver
  import delta_pkg::*;
#(
  parameter int HALF_PERIOD  = SCLK_HALF,
  parameter int LAG          = CAPTURE_LAG,
  parameter int SETTLE       = SETTLE_CYCLES,
  parameter int WINDOW       = DECIM,
  parameter int WIDTH        = WORD_W,
  parameter int DEPTH        = FIFO_DEPTH,
  parameter int FAULT_LENGTH = FAULT_RUN
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  delta_link.host               link,
  input  wire logic             run,
  input  wire logic             manchester_mode,
  output logic      [WIDTH-1:0] word_data,
  output logic                  word_valid,
  input  wire logic             word_ready,
  output logic                  settled,
  output logic                  cm_fault_seen,
  output logic                  overrun
);
  localparam int HW = $clog2(HALF_PERIOD) + 1;
  localparam int SW = $clog2(SETTLE + 1);
  localparam int RW = $clog2(FAULT_LENGTH + 2);

  logic [HW-1:0]    half_cnt_r;
  logic             sclk_r;
  logic             mode_r;
  logic [SW-1:0]    settle_cnt_r;
  logic [LAG-1:0]   lag_r;
  logic             line_ff1_r;
  logic             line_ff2_r;
  logic             line_ff3_r;
  logic             line_stable_r;
  logic             bit_val;
  logic             capture;
  logic [RW-1:0]    high_run_r;
  logic [WIDTH-1:0] ones_r;
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] pend_data_r;
  logic             pend_r;
  logic             pend_ready;

  // clock divider; on stop the clock finishes its high half and rests low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      half_cnt_r <= '0;
      sclk_r     <= 1'b0;
    end else if (run || sclk_r) begin
      if (half_cnt_r == HW'(HALF_PERIOD - 1)) begin
        half_cnt_r <= '0;
        sclk_r     <= !sclk_r;
      end else begin
        half_cnt_r <= half_cnt_r + 1'b1;
      end
    end else begin
      half_cnt_r <= '0;
    end
  end

  // mode moves only while the clock is low so the stream is never inverted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_UNCODED;
    end else if (!sclk_r) begin
      mode_r <= manchester_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_cnt_r <= '0;
    end else if (!run) begin
      settle_cnt_r <= '0;
    end else if (settle_cnt_r != SW'(SETTLE)) begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end
  assign settled = settle_cnt_r == SW'(SETTLE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_ff1_r    <= 1'b0;
      line_ff2_r    <= 1'b0;
      line_ff3_r    <= 1'b0;
      line_stable_r <= 1'b0;
    end else begin
      line_ff1_r <= link.bitstream;
      line_ff2_r <= line_ff1_r;
      line_ff3_r <= line_ff2_r;
      if (agree_change(line_ff2_r, line_ff3_r, line_stable_r)) begin
        line_stable_r <= line_ff3_r;
      end
    end
  end

  // capture point trails each rising edge by the round-trip latency
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lag_r <= '0;
    end else begin
      lag_r <= {lag_r[LAG-2:0], (run && !sclk_r && half_cnt_r == HW'(HALF_PERIOD - 1))};
    end
  end
  assign capture = lag_r[LAG-1];
  // high half of a Manchester bit carries the inverted data
  assign bit_val = line_stable_r ^ mode_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_run_r    <= '0;
      cm_fault_seen <= 1'b0;
    end else if (capture) begin
      if (!bit_val) begin
        high_run_r <= '0;
      end else if (high_run_r != RW'(FAULT_LENGTH + 1)) begin
        high_run_r <= high_run_r + 1'b1;
      end
      cm_fault_seen <= bit_val && (high_run_r >= RW'(FAULT_LENGTH));
    end
  end

  // a full fifo stalls the window; bits arriving meanwhile are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ones_r      <= '0;
      count_r     <= '0;
      pend_r      <= 1'b0;
      pend_data_r <= '0;
      overrun     <= 1'b0;
    end else begin
      if (pend_r && pend_ready) begin
        pend_r <= 1'b0;
      end
      if (capture && settled) begin
        if (pend_r && !pend_ready) begin
          overrun <= 1'b1;
        end else if (count_r == WIDTH'(WINDOW - 1)) begin
          pend_data_r <= ones_r + WIDTH'(bit_val);
          pend_r      <= 1'b1;
          ones_r      <= '0;
          count_r     <= '0;
        end else begin
          ones_r  <= ones_r + WIDTH'(bit_val);
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

  stream_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (pend_r),
    .in_ready  (pend_ready),
    .in_data   (pend_data_r),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  assign link.sample_clock     = sclk_r;
  assign link.line_code_select = mode_r;
endmodule

//--- delta_link_chk.sv
// assertions on the pins between the modulator and the receiver
module delta_link_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sample_clock,
  input wire logic line_code_select,
  input wire logic bitstream
);
  logic [7:0] sc_d;
  logic [7:0] sel_d;
  logic       uncoded;
  logic       coded;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sc_d  <= 8'h00;
      sel_d <= 8'h00;
    end else begin
      sc_d  <= {sc_d[6:0], sample_clock};
      sel_d <= {sel_d[6:0], line_code_select};
    end
  end

  // eight cycles of history outlast the device's four-cycle view of a new code
  assign uncoded = !line_code_select && (sel_d == 8'h00);
  assign coded   = line_code_select && (sel_d == 8'hff);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_uncoded_rise;
    ($changed(bitstream) && uncoded) |-> (sc_d[3] && !sc_d[4]);
  endproperty
  a_uncoded_rise: assert property (p_uncoded_rise)
    else $error("uncoded bit moved off a sample rise");

  property p_bit_once;
    ($changed(bitstream) && uncoded) |=> $stable(bitstream)[*3];
  endproperty
  a_bit_once: assert property (p_bit_once)
    else $error("uncoded bit moved twice in one sample period");

  property p_manch_edges;
    ($changed(bitstream) && coded) |-> (sc_d[3] != sc_d[4]);
  endproperty
  a_manch_edges: assert property (p_manch_edges)
    else $error("coded half bit not aligned to a clock edge");

  property p_manch_mid;
    ($fell(sample_clock) && coded) |-> ##4 $changed(bitstream);
  endproperty
  a_manch_mid: assert property (p_manch_mid)
    else $error("coded bit without a mid-bit transition");

  property p_freeze;
    (sc_d[5:0] == {6{sample_clock}}) |-> $stable(bitstream);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("stream moved while the sample clock stood still");

  property p_sclk_high;
    $rose(sample_clock) |-> sample_clock[*2] ##1 !sample_clock;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("sample clock high half not two cycles");

  property p_sclk_low;
    $fell(sample_clock) |-> !sample_clock[*2];
  endproperty
  a_sclk_low: assert property (p_sclk_low)
    else $error("sample clock low half shorter than two cycles");

  property p_select_low;
    $changed(line_code_select) |-> (!sample_clock || !$past(sample_clock));
  endproperty
  a_select_low: assert property (p_select_low)
    else $error("line code changed while the sample clock was high");

  c_uncoded: cover property (uncoded && $changed(bitstream));
  c_coded: cover property (coded && $changed(bitstream));
  c_frozen: cover property ((sc_d == 8'h00) && !sample_clock && bitstream);
endmodule

//--- test_modulator_bitstream_output.sv
// self-checking bench for the modulator, its receiver and the link between them
module test_modulator_bitstream_output
  import delta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 16;
  localparam int WW  = $clog2(WIN) + 1;
  localparam int SET = 50;
  logic                   clk;
  logic                   rst_b;
  logic                   run;
  logic                   manchester_mode;
  logic                   word_ready;
  logic signed [IN_W-1:0] pos;
  logic signed [IN_W-1:0] neg;
  logic        [WW-1:0]   word_data;
  logic                   word_valid;
  logic                   settled;
  logic                   cm_fault_seen;
  logic                   overrun;
  logic                   chop_phase;
  logic                   clipped;
  logic                   cm_fault;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  int                     n_words    = 0;
  int                     sum_w      = 0;
  int                     vt [4]     = '{0, 8000, -8000, 4000};

  delta_link link ();
  // second link: the bench plays a host that breaks the select timing
  delta_link bad ();

  modulator_bitstream_output modulator_bitstream_output_inst (.clk(clk), .rst_b(rst_b),
    .link(link), .analog_in_pos(pos), .analog_in_neg(neg), .chop_phase(chop_phase),
    .clipped(clipped), .cm_fault(cm_fault));
  modulator_bitstream_output modulator_bitstream_output_inst2 (.clk(clk), .rst_b(rst_b),
    .link(bad), .analog_in_pos(pos), .analog_in_neg(neg), .chop_phase(), .clipped(),
    .cm_fault());
  decimating_receiver #(.SETTLE(SET), .WINDOW(WIN), .WIDTH(WW)) decimating_receiver_inst (
    .clk(clk), .rst_b(rst_b), .link(link), .run(run), .manchester_mode(manchester_mode),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
    .settled(settled), .cm_fault_seen(cm_fault_seen), .overrun(overrun));
  delta_link_chk delta_link_chk_inst (.clk(clk), .rst_b(rst_b),
    .sample_clock(link.sample_clock), .line_code_select(link.line_code_select),
    .bitstream(link.bitstream));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (word_valid === 1'h1 && word_ready === 1'h1) begin
      n_words <= n_words + 1;
      sum_w   <= sum_w + int'(word_data);
    end
  end

  task chk(input string nm, input logic [15:0] lo, input logic [15:0] hi,
           input logic [15:0] got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'h1) begin
      n_mismatch++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // two words are dropped: the pipeline still holds bits taken before an
  // input or mode change, and the loop needs a few bits to settle
  task words(input int k, output int s);
    int t;
    int s0;
    t = n_words + 2;
    for (int i = 0; i < 4000 && n_words < t; i++) @(negedge clk);
    s0 = sum_w;
    t = n_words + k;
    for (int i = 0; i < 400 * k && n_words < t; i++) @(negedge clk);
    s = sum_w - s0;
  endtask

  task wire_bits(output int ones, output int gap);
    int last;
    ones = 0;
    gap  = 0;
    last = -1;
    for (int b = 0; b < 256; b++) begin
      @(posedge link.sample_clock);
      repeat (2) @(negedge clk);
      if (link.bitstream === 1'h1) begin
        ones++;
        if (last >= 0) gap = b - last;
        last = b;
      end
    end
  endtask

  task chop_rises(output int n);
    logic p;
    logic s;
    n = 0;
    p = chop_phase;
    for (int i = 0; i < 300 && chop_phase === p; i++) @(negedge clk);
    p = chop_phase;
    s = link.sample_clock;
    for (int i = 0; i < 300 && chop_phase === p; i++) begin
      @(negedge clk);
      n += int'(link.sample_clock && !s);
      s = link.sample_clock;
    end
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(40000 * 20);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    int e;
    int k;
    int gap;
    logic b;
    rst_b = 1'h0;
    run = 1'h0;
    manchester_mode = 1'h0;
    word_ready = 1'h1;
    pos = 16'h0000;
    neg = 16'h0000;
    bad.sample_clock = 1'h0;
    bad.line_code_select = 1'h0;
    repeat (6) @(negedge clk);
    rst_b = 1'h1;
    run = 1'h1;
    repeat (SET - 5) @(negedge clk);
    chk("settled early", 0, 0, settled);
    repeat (10) @(negedge clk);
    chk("settled", 1, 1, settled);
    $display("settle test done");
    for (int m = 0; m < 8; m++) begin
      manchester_mode = m[2];
      pos = 16'(vt[m % 4] / 2);
      neg = 16'(-vt[m % 4] / 2);
      e = 32 * (vt[m % 4] + CLIP_CODE) / (2 * CLIP_CODE);
      words(2, k);
      chk("ones in 32 bits", 16'(e - 3), 16'(e + 3), 16'(k));
    end
    $display("density test done");
    for (int m = 0; m < 4; m++) begin
      manchester_mode = m[1];
      pos = 16'((m[0] ? 1 : -1) * CLIP_CODE * 13 / 20);
      neg = -pos;
      e = m[0] ? 254 : 2;
      words(16, k);
      chk("clipped ones", 16'(e), 16'(e), 16'(k));
      chk("clipped flag", 1, 1, clipped);
      chk("no fault on clip", 0, 0, cm_fault_seen);
    end
    manchester_mode = 1'h0;
    pos = 16'(-CLIP_CODE * 13 / 20);
    neg = -pos;
    repeat (40) @(negedge clk);
    wire_bits(k, gap);
    chk("marker count", 2, 2, 16'(k));
    chk("marker gap", 128, 128, 16'(gap));
    for (int i = 0; i < 2; i++) begin
      pos = 16'((i == 0) ? CM_HIGH_CODE : CM_LOW_CODE);
      neg = pos;
      words(10, k);
      chk("fault ones", 160, 160, 16'(k));
      chk("fault flag", 1, 1, cm_fault);
      chk("fault seen", 1, 1, cm_fault_seen);
    end
    pos = 16'h0000;
    neg = 16'h0000;
    chop_rises(k);
    chk("rises per chop half", CHOP_DIV / 2, CHOP_DIV / 2, 16'(k));
    $display("clip and fault tests done");
    run = 1'h0;
    repeat (20) @(negedge clk);
    b = link.bitstream;
    k = n_words;
    repeat (200) @(negedge clk);
    chk("frozen bit", b, b, link.bitstream);
    chk("stopped clock", 0, 0, link.sample_clock);
    chk("settled off", 0, 0, settled);
    run = 1'h1;
    repeat (SET - 5) @(negedge clk);
    chk("words while settling", 16'(k), 16'(k), 16'(n_words));
    $display("freeze test done");
    pos = 16'(CLIP_CODE * 13 / 20);
    neg = -pos;
    repeat (5) begin
      bad.sample_clock = 1'h1;
      repeat (2) @(negedge clk);
      bad.sample_clock = 1'h0;
      repeat (2) @(negedge clk);
    end
    bad.sample_clock = 1'h1;
    repeat (8) @(negedge clk);
    chk("bad host bit", 1, 1, bad.bitstream);
    bad.line_code_select = 1'h1;
    repeat (8) @(negedge clk);
    chk("select flip while high", 0, 0, bad.bitstream);
    $display("select test done");
    word_ready = 1'h0;
    for (int i = 0; i < 4000 && overrun !== 1'h1; i++) @(negedge clk);
    chk("overrun", 1, 1, overrun);
    run = 1'h0;
    repeat (20) @(negedge clk);
    k = n_words;
    word_ready = 1'h1;
    repeat (80) @(negedge clk);
    chk("words drained", FIFO_DEPTH, FIFO_DEPTH + 1, 16'(n_words - k));
    chk("fifo empty", 0, 0, word_valid);
    rst_b = 1'h0;
    repeat (3) @(negedge clk);
    chk("overrun after reset", 0, 0, overrun);
    chk("stream after reset", 0, 0, link.bitstream);
    rst_b = 1'h1;
    $display("fifo and reset test done");
    wrap_up();
  end
endmodule
